/* File: rtl/mim_defs.vh */
// Constants for the multi-function input mapper
`ifndef MIM_DEFS_VH
`define MIM_DEFS_VH
`define MIM_NUM_TERM 7
`define MIM_SEL_W 16
`define MIM_FREQ_W 16
`define MIM_ADDR_W 4
// Register offsets (word index)
`define MIM_REG_IN1_SEL 4'h0
`define MIM_REG_IN2_SEL 4'h1
`define MIM_REG_IN3_SEL 4'h2
`define MIM_REG_IN4_SEL 4'h3
`define MIM_REG_IN5_SEL 4'h4
`define MIM_REG_AN1_SEL 4'h5
`define MIM_REG_AN2_SEL 4'h6
`define MIM_REG_CTRL 4'h7
`define MIM_REG_RAMP 4'h8
`define MIM_REG_BASE 4'h9
`define MIM_REG_MONITOR 4'hA
`define MIM_REG_FINAL 4'hB
`define MIM_REG_STATUS 4'hC
// Reset values of the selection codes and the ramp register
`define MIM_RST_IN1 16'h0001
`define MIM_RST_IN2 16'h0002
`define MIM_RST_IN3 16'h000B
`define MIM_RST_IN4 16'h000C
`define MIM_RST_IN5 16'h000D
`define MIM_RST_AN 16'h0000
`define MIM_RST_RAMP 16'h0001
// Function codes
`define MIM_FN_NONE 16'h0000
`define MIM_FN_RUN 16'h0001
`define MIM_FN_DIR 16'h0002
`define MIM_FN_STOP3 16'h0003
`define MIM_FN_FINCH 16'h0004
`define MIM_FN_RINCH 16'h0005
`define MIM_FN_UP 16'h0006
`define MIM_FN_DOWN 16'h0007
`define MIM_FN_CLR 16'h0008
// Control register fields
`define MIM_CTRL_SRC_LSB 0
`define MIM_CTRL_SRC_MSB 1
`define MIM_CTRL_MODE_LSB 2
`define MIM_CTRL_MODE_MSB 3
`define MIM_CTRL_NOREV 4
`define MIM_CTRL_SRCA 5
`define MIM_CTRL_W 6
`define MIM_SRC_TERMINAL 2'h1
`define MIM_MODE_3LINE1 2'h2
`define MIM_MODE_3LINE2 2'h3
`endif

/* File: rtl/mim_input_mapper.v */
// Multi-function input terminal mapper with up/down frequency offset
//
// Overview of operation
// - Seven terminals: five digital, two analog-derived
// - Per-terminal selection codes with documented reset defaults
// - Shared functions combine by OR
// - Selection zero drives no function
// - Code 1 run request under terminal control
// - Code 2 direction under terminal control
// - Code 3 stop in three-line modes only
// - Inch forward/reverse; both stops the drive
// - Reverse inch ignored while reverse prohibited
// - Up/down move offset at ramp rate
// - Code 8 clears the offset to zero
// - Final setpoint is base plus offset
// - Offset only applies while source A used
// - Offset readable through monitor register
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`include "mim_defs.vh"
`default_nettype none
module mim_input_mapper (
  input wire clk_i,
  input wire srst_i,
  input wire [4:0] digital_input_i,
  input wire [1:0] analog_input_i,
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  output reg run_o,
  output reg direction_o,
  output reg stop_o,
  output reg forward_inch_o,
  output reg reverse_inch_o,
  output reg inch_decel_stop_o,
  output reg [15:0] offset_monitor_o,
  output reg [15:0] final_setpoint_o
);

  localparam N = `MIM_NUM_TERM;

  reg [6:0] sync1_q;
  reg [6:0] sync2_q;
  reg [15:0] sel_q [0:6];
  reg [`MIM_CTRL_W-1:0] ctrl_q;
  reg [15:0] ramp_q;
  reg [15:0] base_q;
  reg [15:0] offset_q;
  reg [15:0] offset_d;
  reg [15:0] final_d;
  reg [15:0] rdata_d;
  wire [6:0] term_w;
  wire [6:0] hit_run;
  wire [6:0] hit_dir;
  wire [6:0] hit_stop;
  wire [6:0] hit_fin;
  wire [6:0] hit_rin;
  wire [6:0] hit_up;
  wire [6:0] hit_dn;
  wire [6:0] hit_clr;
  wire [16:0] up_sum;
  wire term_ctrl;
  wire three_line;
  wire fn_run;
  wire fn_dir;
  wire fn_stop;
  wire fn_fin;
  wire fn_rin;
  wire fn_up;
  wire fn_dn;
  wire fn_clr;

  // Terminal sampling
  always @(posedge clk_i) begin
    if (srst_i) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {analog_input_i, digital_input_i};
      sync2_q <= sync1_q;
    end
  end

  assign term_w = sync2_q;

  // Per-terminal decode
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_term
      // Code 0 matches no function
      assign hit_run[g] = term_w[g] & (sel_q[g] == `MIM_FN_RUN);
      assign hit_dir[g] = term_w[g] & (sel_q[g] == `MIM_FN_DIR);
      assign hit_stop[g] = term_w[g] & (sel_q[g] == `MIM_FN_STOP3);
      assign hit_fin[g] = term_w[g] & (sel_q[g] == `MIM_FN_FINCH);
      assign hit_rin[g] = term_w[g] & (sel_q[g] == `MIM_FN_RINCH);
      assign hit_up[g] = term_w[g] & (sel_q[g] == `MIM_FN_UP);
      assign hit_dn[g] = term_w[g] & (sel_q[g] == `MIM_FN_DOWN);
      assign hit_clr[g] = term_w[g] & (sel_q[g] == `MIM_FN_CLR);
    end
  endgenerate

  // OR across terminals
  assign fn_run = |hit_run;
  assign fn_dir = |hit_dir;
  assign fn_stop = |hit_stop;
  assign fn_fin = |hit_fin;
  assign fn_rin = (|hit_rin) & ~ctrl_q[`MIM_CTRL_NOREV];
  assign fn_up = |hit_up;
  assign fn_dn = |hit_dn;
  assign fn_clr = |hit_clr;

  assign term_ctrl =
    (ctrl_q[`MIM_CTRL_SRC_MSB:`MIM_CTRL_SRC_LSB] == `MIM_SRC_TERMINAL);
  assign three_line =
    (ctrl_q[`MIM_CTRL_MODE_MSB:`MIM_CTRL_MODE_LSB] == `MIM_MODE_3LINE1) ||
    (ctrl_q[`MIM_CTRL_MODE_MSB:`MIM_CTRL_MODE_LSB] == `MIM_MODE_3LINE2);

  assign up_sum = {1'b0, offset_q} + {1'b0, ramp_q};

  // Offset accumulator next value
  always @* begin
    offset_d = offset_q;
    if (fn_clr) begin
      offset_d = 16'h0000;
    end else if (fn_up && !fn_dn) begin
      if (up_sum[16]) begin
        offset_d = 16'hFFFF;
      end else begin
        offset_d = up_sum[15:0];
      end
    end else if (fn_dn && !fn_up) begin
      if (offset_q < ramp_q) begin
        offset_d = 16'h0000;
      end else begin
        offset_d = offset_q - ramp_q;
      end
    end
  end

  // Final setpoint
  always @* begin
    final_d = base_q;
    if (ctrl_q[`MIM_CTRL_SRCA]) begin
      final_d = base_q + offset_q;
    end
  end

  // Read mux
  always @* begin
    rdata_d = 16'h0000;
    case (addr_i)
      `MIM_REG_IN1_SEL: rdata_d = sel_q[0];
      `MIM_REG_IN2_SEL: rdata_d = sel_q[1];
      `MIM_REG_IN3_SEL: rdata_d = sel_q[2];
      `MIM_REG_IN4_SEL: rdata_d = sel_q[3];
      `MIM_REG_IN5_SEL: rdata_d = sel_q[4];
      `MIM_REG_AN1_SEL: rdata_d = sel_q[5];
      `MIM_REG_AN2_SEL: rdata_d = sel_q[6];
      `MIM_REG_CTRL: rdata_d = {10'h000, ctrl_q};
      `MIM_REG_RAMP: rdata_d = ramp_q;
      `MIM_REG_BASE: rdata_d = base_q;
      `MIM_REG_MONITOR: rdata_d = offset_q;
      `MIM_REG_FINAL: rdata_d = final_setpoint_o;
      `MIM_REG_STATUS: rdata_d = {9'h000, term_w};
      default: rdata_d = 16'h0000;
    endcase
  end

  // Registers and outputs
  always @(posedge clk_i) begin
    if (srst_i) begin
      sel_q[0] <= `MIM_RST_IN1;
      sel_q[1] <= `MIM_RST_IN2;
      sel_q[2] <= `MIM_RST_IN3;
      sel_q[3] <= `MIM_RST_IN4;
      sel_q[4] <= `MIM_RST_IN5;
      sel_q[5] <= `MIM_RST_AN;
      sel_q[6] <= `MIM_RST_AN;
      ctrl_q <= {`MIM_CTRL_W{1'b0}};
      ramp_q <= `MIM_RST_RAMP;
      base_q <= 16'h0000;
      offset_q <= 16'h0000;
      rdata_o <= 16'h0000;
      run_o <= 1'b0;
      direction_o <= 1'b0;
      stop_o <= 1'b0;
      forward_inch_o <= 1'b0;
      reverse_inch_o <= 1'b0;
      inch_decel_stop_o <= 1'b0;
      offset_monitor_o <= 16'h0000;
      final_setpoint_o <= 16'h0000;
    end else begin
      if (wr_i) begin
        case (addr_i)
          `MIM_REG_IN1_SEL: sel_q[0] <= wdata_i;
          `MIM_REG_IN2_SEL: sel_q[1] <= wdata_i;
          `MIM_REG_IN3_SEL: sel_q[2] <= wdata_i;
          `MIM_REG_IN4_SEL: sel_q[3] <= wdata_i;
          `MIM_REG_IN5_SEL: sel_q[4] <= wdata_i;
          `MIM_REG_AN1_SEL: sel_q[5] <= wdata_i;
          `MIM_REG_AN2_SEL: sel_q[6] <= wdata_i;
          `MIM_REG_CTRL: ctrl_q <= wdata_i[`MIM_CTRL_W-1:0];
          `MIM_REG_RAMP: ramp_q <= wdata_i;
          `MIM_REG_BASE: base_q <= wdata_i;
          default: ;
        endcase
      end
      rdata_o <= rd_i ? rdata_d : 16'h0000;
      offset_q <= offset_d;
      run_o <= term_ctrl & fn_run;
      direction_o <= term_ctrl & fn_dir;
      stop_o <= term_ctrl & three_line & fn_stop;
      forward_inch_o <= term_ctrl & fn_fin & ~fn_rin;
      reverse_inch_o <= term_ctrl & fn_rin & ~fn_fin;
      inch_decel_stop_o <= term_ctrl & fn_fin & fn_rin;
      offset_monitor_o <= offset_q;
      final_setpoint_o <= final_d;
    end
  end

endmodule
`default_nettype wire

/* File: tb/mim_input_mapper_assertions.sv */
// Port checker for the input mapper
`default_nettype none
module mim_map_chk (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic run_o,
  input wire logic direction_o,
  input wire logic stop_o,
  input wire logic forward_inch_o,
  input wire logic reverse_inch_o,
  input wire logic inch_decel_stop_o,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic [15:0] offset_monitor_o,
  input wire logic [15:0] final_setpoint_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] ctrl_q;
  logic [15:0] base_q, ramp_q;
  logic act;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  assign act = run_o | direction_o | stop_o | forward_inch_o |
    reverse_inch_o | inch_decel_stop_o;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q <= 6'h00;
      base_q <= 16'h0000;
      ramp_q <= 16'h0001;
    end else if (wr_i) begin
      if (addr_i == 4'h7) ctrl_q <= wdata_i[5:0];
      if (addr_i == 4'h8) ramp_q <= wdata_i;
      if (addr_i == 4'h9) base_q <= wdata_i;
    end
  end
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside a read");
  a_inch_excl: assert property (!(forward_inch_o && reverse_inch_o))
    else $error("both inch outputs high");
  a_decel_only: assert property (inch_decel_stop_o |->
    !forward_inch_o && !reverse_inch_o && !$past(ctrl_q[4]))
    else $error("inch stop with other inch output");
  a_term_gate: assert property (act |-> $past(ctrl_q[1:0]) == 2'h1)
    else $error("function output without terminal control");
  a_stop_mode: assert property (stop_o |-> $past(ctrl_q[3]))
    else $error("stop outside three-line mode");
  a_rev_gate: assert property (reverse_inch_o |-> !$past(ctrl_q[4]))
    else $error("reverse inch while reverse prohibited");
  a_final_sum: assert property (final_setpoint_o == 16'(
    $past(ctrl_q[5]) ? $past(base_q) + offset_monitor_o : $past(base_q)))
    else $error("final setpoint mismatch");
  a_offset_step: assert property ($changed(offset_monitor_o) &&
    offset_monitor_o != 16'h0000 && offset_monitor_o != 16'hFFFF |->
    offset_monitor_o == 16'($past(offset_monitor_o) + $past(ramp_q, 2)) ||
    offset_monitor_o == 16'($past(offset_monitor_o) - $past(ramp_q, 2)))
    else $error("offset step not one ramp");
endmodule
bind mim_input_mapper mim_map_chk u_chk (.clk_i, .srst_i, .wr_i, .rd_i,
  .run_o, .direction_o, .stop_o, .forward_inch_o, .reverse_inch_o,
  .inch_decel_stop_o, .addr_i, .wdata_i, .rdata_o, .offset_monitor_o,
  .final_setpoint_o);
`default_nettype wire

/* File: tb/mim_term_model.sv */
// Switch model driving the seven terminals
`default_nettype none
module mim_term_model (
  input wire logic clk_i,
  input wire logic [6:0] lvl_i,
  output logic [4:0] dig_o,
  output logic [1:0] ana_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {ana_o, dig_o} = 7'h00;
  always @(posedge clk_i) {ana_o, dig_o} <= lvl_i;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the input mapper
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, rd_d = 0;
  logic run_o, direction_o, stop_o, forward_inch_o, reverse_inch_o;
  logic inch_decel_stop_o;
  logic [1:0] prb = 0, analog_input_i;
  logic [3:0] addr_i = 0;
  logic [4:0] digital_input_i;
  logic [6:0] lvl = 0;
  logic [15:0] wdata_i = 0, rdata_o, offset_monitor_o, final_setpoint_o;
  logic [15:0] e, r, b, rv[7];
  logic [31:0] rng = 32'h41F5;
  logic [15:0] q[$];
  int n_mismatch = 0, n_tests = 0;
  mim_input_mapper DUT (.clk_i, .srst_i, .digital_input_i, .analog_input_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .run_o, .direction_o,
    .stop_o, .forward_inch_o, .reverse_inch_o, .inch_decel_stop_o,
    .offset_monitor_o, .final_setpoint_o);
  mim_term_model u_sw (.clk_i, .lvl_i(lvl), .dig_o(digital_input_i),
    .ana_o(analog_input_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic cmp16(input logic [15:0] g, x);
    n_tests++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_fn(input logic [5:0] g, x);
    cmp16({10'h000, g}, {10'h000, x});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] x);
    q.push_back(x);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_i);
    rd_i <= 1'h0;
  endtask
  task automatic chk(input logic [1:0] k, input logic [15:0] x);
    repeat (6) @(posedge clk_i);
    q.push_back(x);
    prb <= k;
    @(posedge clk_i);
    prb <= 2'h0;
  endtask
  task automatic drive(input logic [6:0] v, input int n);
    @(posedge clk_i);
    lvl <= v;
    repeat (n) @(posedge clk_i);
    lvl <= 7'h00;
  endtask
  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    rd_d <= rd_i;
    if (rd_d) cmp16(rdata_o, q.pop_front());
    if (prb != 2'h0) e = q.pop_front();
    if (prb == 2'h1) cmp_fn({run_o, direction_o, stop_o, forward_inch_o,
      reverse_inch_o, inch_decel_stop_o}, e[5:0]);
    if (prb == 2'h2) cmp16(offset_monitor_o, e);
    if (prb == 2'h3) cmp16(final_setpoint_o, e);
  end
  initial forever #4 clk_i = ~clk_i;
  initial begin
    repeat (2000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    rv = '{16'h0001, 16'h0002, 16'h000B, 16'h000C, 16'h000D, 16'h0000,
      16'h0000};
    repeat (4) @(posedge clk_i);
    srst_i <= 1'h0;
    for (int i = 0; i < 7; i++) rd(i[3:0], rv[i]);
    rd(4'hF, 16'h0000);
    wr(4'h7, 16'h0029);
    wr(4'h6, 16'h0001);
    rd(4'h6, 16'h0001);
    rd(4'h7, 16'h0029);
    lvl <= 7'h60;
    chk(2'h1, 16'h0020);
    for (int c = 1; c < 6; c++) begin
      wr(4'h1, c[15:0]);
      rng = xs(rng);
      lvl <= {2'h0, rng[2:0], 2'h2};
      chk(2'h1, 16'h0040 >> c);
    end
    wr(4'h0, 16'h0004);
    lvl <= 7'h03;
    chk(2'h1, 16'h0001);
    rd(4'hC, 16'h0003);
    wr(4'h7, 16'h0039);
    chk(2'h1, 16'h0004);
    wr(4'h7, 16'h0028);
    chk(2'h1, 16'h0000);
    lvl <= 7'h00;
    rng = xs(rng);
    r = {12'h000, rng[3:0] | 4'h1};
    b = rng[31:16];
    wr(4'h8, r);
    wr(4'h9, b);
    wr(4'h0, 16'h0006);
    wr(4'h1, 16'h0007);
    wr(4'h5, 16'h0008);
    wr(4'h7, 16'h0021);
    drive(7'h01, 5);
    chk(2'h2, r * 16'h0005);
    drive(7'h02, 2);
    chk(2'h3, b + r * 16'h0003);
    wr(4'hA, 16'hFFFF);
    rd(4'hA, r * 16'h0003);
    rd(4'hB, b + r * 16'h0003);
    rd(4'h8, r);
    rd(4'h9, b);
    drive(7'h20, 1);
    chk(2'h2, 16'h0000);
    wr(4'h7, 16'h0001);
    chk(2'h3, b);
    give_verdict();
  end
endmodule
`default_nettype wire
